// ==== core/ufs_regs.svh ====
// Constants for the FIFO-bus master: command codes, lane masks, depths.
// Assumes a 32-bit data bus with four byte-lane valid pins.
`ifndef UFS_REGS_SVH
`define UFS_REGS_SVH
`define UFS_CMD_RD 4'h0
`define UFS_CMD_WR 4'h1
`define UFS_LANE_IDLE_OE 32'hFFFF00FF
`define UFS_LANE_ALL 32'hFFFFFFFF
`define UFS_LANE_NONE 32'h00000000
`define UFS_IDLE_DATA 32'hFFFFFFFF
`define UFS_BE_ALL 4'hF
`define UFS_ST_LSB 8
`define UFS_CHAN_LSB 0
`define UFS_FIFO_DEPTH 16
`define UFS_LEN_W 12
`endif

// ==== core/ufs_pkg.sv ====
// Types shared by the FIFO-bus master and its buffers.
// Assumes ufs_regs.svh is on the include path.
`include "ufs_regs.svh"
package ufs_pkg;
    typedef enum logic [3:0] {S_IDLE, S_CMD, S_RD, S_WR_TA, S_WR, S_END_TA,
                              S_F_RD_OE, S_F_RD, S_F_WR} ufs_state_t;
    typedef struct packed {
        logic [3:0] be;
        logic [31:0] dat;
    } ufs_word_t;
endpackage : ufs_pkg

// ==== core/ufs_strm_if.sv ====
// Valid/ready stream between the master and its buffers.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface ufs_strm_if #(parameter int W = 36);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ufs_strm_if
`default_nettype wire

// ==== core/ufs_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ufs_fifo #(
    parameter int W = 36,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    ufs_strm_if.snk in_s,
    ufs_strm_if.src out_s,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem[rp_r];
    assign level_o = cnt_r;

    always_comb
    begin
        push = in_s.valid && in_s.ready;
        pop = out_s.valid && out_s.ready;
        wp_nxt = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
        rp_nxt = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; contents are only read while counted valid
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wp_r] <= in_s.data;
        end
    end
endmodule : ufs_fifo
`default_nettype wire

// ==== core/ufs_host.sv ====
// Master for a USB FIFO-bridge slave bus: multi-channel and 245 modes.
// Assumes the slave makes bus_clk_i; every bus pin is sampled by clock_i.
`timescale 1ns/1ns
`default_nettype none
`include "ufs_regs.svh"
module ufs_host
    import ufs_pkg::*;
#(
    parameter int DEPTH = `UFS_FIFO_DEPTH,
    parameter int LEN_W = `UFS_LEN_W
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic mc_mode_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_chan_i,
    input wire logic [LEN_W-1:0] cmd_len_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [3:0] wr_be_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    output logic [31:0] rd_data_o,
    output logic [3:0] rd_be_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic busy_o,
    output logic xfer_done_o,
    output logic [LEN_W-1:0] xfer_words_o,
    output logic [7:0] chan_status_o,
    input wire logic bus_clk_i,
    input wire logic [31:0] data_i,
    output logic [31:0] data_o,
    output logic [31:0] data_oe_o,
    input wire logic [3:0] byte_lane_valid_i,
    output logic [3:0] byte_lane_valid_o,
    output logic [3:0] byte_lane_valid_oe_o,
    output logic wr_req_low_o,
    output logic rd_req_low_o,
    output logic out_en_req_low_o,
    input wire logic rx_data_avail_low_i,
    input wire logic tx_space_avail_low_i
);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [LW-1:0] LVL_LAST = LW'(DEPTH - 1);
    localparam logic [LW-1:0] LVL_ONE = LW'(1);
    localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);
    localparam int PW = 39;

    // ==========================================================
    // Reset release and pin sampling
    logic rst_s1, rst_n;
    logic [PW-1:0] pin_s1, pin_s2, pin_s3;
    logic rise, rxf_q, txe_q;
    logic [31:0] d_q;
    logic [3:0] be_q;

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
        end
        else
        begin
            pin_s1 <= {bus_clk_i, rx_data_avail_low_i, tx_space_avail_low_i,
                       byte_lane_valid_i, data_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Stage 3 holds the pins one sample before the seen edge, so values
    // the slave changes just after its edge are not mistaken for old ones
    assign rise = pin_s2[PW-1] && !pin_s3[PW-1];
    assign rxf_q = pin_s3[PW-2];
    assign txe_q = pin_s3[PW-3];
    assign be_q = pin_s3[35:32];
    assign d_q = pin_s3[31:0];

    // ==========================================================
    // Data buffers
    ufs_strm_if #(.W($bits(ufs_word_t))) tx_in();
    ufs_strm_if #(.W($bits(ufs_word_t))) tx_out();
    ufs_strm_if #(.W($bits(ufs_word_t))) rx_in();
    ufs_strm_if #(.W($bits(ufs_word_t))) rx_out();
    logic [LW-1:0] tx_level, rx_level;
    ufs_word_t tx_head, rx_tail;
    logic tx_pop, rx_push;

    ufs_fifo #(.W($bits(ufs_word_t)), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_i(clock_i),
        .rst_n_i(rst_n),
        .in_s(tx_in),
        .out_s(tx_out),
        .level_o(tx_level)
    );

    ufs_fifo #(.W($bits(ufs_word_t)), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_i(clock_i),
        .rst_n_i(rst_n),
        .in_s(rx_in),
        .out_s(rx_out),
        .level_o(rx_level)
    );

    assign tx_in.valid = wr_valid_i;
    assign tx_in.data = {wr_be_i, wr_data_i};
    assign wr_ready_o = tx_in.ready;
    assign tx_head = tx_out.data;
    assign tx_out.ready = tx_pop;
    assign rx_tail = rx_out.data;
    assign rd_data_o = rx_tail.dat;
    assign rd_be_o = rx_tail.be;
    assign rd_valid_o = rx_out.valid;
    assign rx_out.ready = rd_ready_i;
    assign rx_in.valid = rx_push;
    assign rx_in.data = {be_q, d_q};

    // ==========================================================
    // Bus sequencer; state and strobes change only in the cycle after a seen bus edge
    ufs_state_t st_r, st_nxt;
    logic wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt, oe_n_r, oe_n_nxt;
    logic [31:0] dat_r, dat_nxt, dat_oe_r, dat_oe_nxt;
    logic [3:0] be_r, be_nxt;
    logic be_oe_r, be_oe_nxt, write_r, write_nxt, mc_r, mc_nxt;
    logic seen_r, seen_nxt, done_r, done_nxt;
    logic [7:0] chan_r, chan_nxt, status_r, status_nxt;
    logic [LEN_W-1:0] left_r, left_nxt, cnt_r, cnt_nxt;
    logic start_ok, end_xfer;

    assign start_ok = cmd_write_i ? (tx_out.valid && (mc_mode_i || !txe_q))
                                  : (rx_in.ready && (mc_mode_i || !rxf_q));
    assign cmd_ready_o = (st_r == S_IDLE) && rise && start_ok;

    always_comb
    begin
        st_nxt = st_r;
        wr_n_nxt = wr_n_r;
        rd_n_nxt = rd_n_r;
        oe_n_nxt = oe_n_r;
        dat_nxt = dat_r;
        dat_oe_nxt = dat_oe_r;
        be_nxt = be_r;
        be_oe_nxt = be_oe_r;
        write_nxt = write_r;
        mc_nxt = mc_r;
        seen_nxt = seen_r;
        chan_nxt = chan_r;
        status_nxt = status_r;
        left_nxt = left_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        rx_push = 1'b0;
        tx_pop = 1'b0;
        end_xfer = 1'b0;
        case (st_r)
            S_IDLE:
            begin
                mc_nxt = mc_mode_i;
                if (mc_mode_i)
                begin
                    dat_oe_nxt = `UFS_LANE_IDLE_OE;
                    dat_nxt = `UFS_IDLE_DATA;
                    be_nxt = `UFS_BE_ALL;
                    be_oe_nxt = 1'b1;
                    if (rise)
                    begin
                        status_nxt = d_q[`UFS_ST_LSB +: 8];
                    end
                end
                else
                begin
                    dat_oe_nxt = `UFS_LANE_NONE;
                    be_oe_nxt = 1'b0;
                end
                if (cmd_valid_i && cmd_ready_o)
                begin
                    write_nxt = cmd_write_i;
                    chan_nxt = cmd_chan_i;
                    // Length field counts up to 4095 words; a read also ends once the receive FIFO fills
                    left_nxt = cmd_len_i;
                    cnt_nxt = '0;
                    seen_nxt = 1'b0;
                    if (mc_mode_i)
                    begin
                        wr_n_nxt = 1'b0;
                        dat_nxt[`UFS_CHAN_LSB +: 8] = cmd_chan_i;
                        be_nxt = cmd_write_i ? `UFS_CMD_WR : `UFS_CMD_RD;
                        st_nxt = S_CMD;
                    end
                    else if (cmd_write_i)
                    begin
                        wr_n_nxt = 1'b0;
                        dat_oe_nxt = `UFS_LANE_ALL;
                        be_oe_nxt = 1'b1;
                        dat_nxt = tx_head.dat;
                        be_nxt = tx_head.be;
                        st_nxt = S_F_WR;
                    end
                    else
                    begin
                        oe_n_nxt = 1'b0;
                        st_nxt = S_F_RD_OE;
                    end
                end
            end
            S_CMD:
            begin
                if (rise && write_r)
                begin
                    st_nxt = S_WR_TA;
                end
                else if (rise)
                begin
                    dat_oe_nxt = `UFS_LANE_NONE;
                    be_oe_nxt = 1'b0;
                    st_nxt = S_RD;
                end
            end
            S_WR_TA:
            begin
                if (rise)
                begin
                    dat_oe_nxt = `UFS_LANE_ALL;
                    dat_nxt = tx_head.dat;
                    be_nxt = tx_head.be;
                    st_nxt = S_WR;
                end
            end
            S_RD, S_F_RD:
            begin
                if (rise && !rxf_q)
                begin
                    rx_push = 1'b1;
                    seen_nxt = 1'b1;
                    cnt_nxt = cnt_r + LEN_ONE;
                    left_nxt = left_r - LEN_ONE;
                    end_xfer = (left_r == LEN_ONE) || (rx_level == LVL_LAST);
                end
                else if (rise && (seen_r || st_r == S_F_RD))
                begin
                    end_xfer = 1'b1;
                end
            end
            S_WR, S_F_WR:
            begin
                // Head is copied every cycle so a pop is on the pins by the next edge
                dat_nxt = tx_head.dat;
                be_nxt = tx_head.be;
                if (rise && !(st_r == S_WR ? rxf_q : txe_q))
                begin
                    tx_pop = 1'b1;
                    seen_nxt = 1'b1;
                    cnt_nxt = cnt_r + LEN_ONE;
                    left_nxt = left_r - LEN_ONE;
                    // Keeps going while data is queued so packets stay full
                    end_xfer = (left_r == LEN_ONE) || (tx_level == LVL_ONE);
                end
                else if (rise && (seen_r || st_r == S_F_WR))
                begin
                    end_xfer = 1'b1;
                end
            end
            S_END_TA:
            begin
                if (rise)
                begin
                    st_nxt = S_IDLE;
                end
            end
            S_F_RD_OE:
            begin
                if (rise)
                begin
                    rd_n_nxt = 1'b0;
                    st_nxt = S_F_RD;
                end
            end
            default:
            begin
                st_nxt = S_IDLE;
            end
        endcase
        if (end_xfer)
        begin
            wr_n_nxt = 1'b1;
            rd_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            done_nxt = 1'b1;
            if (mc_r)
            begin
                st_nxt = S_END_TA;
                dat_oe_nxt = write_r ? `UFS_LANE_IDLE_OE : `UFS_LANE_NONE;
            end
            else
            begin
                st_nxt = S_IDLE;
                dat_oe_nxt = `UFS_LANE_NONE;
                be_oe_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= S_IDLE;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            dat_r <= '0;
            dat_oe_r <= '0;
            be_r <= '0;
            be_oe_r <= 1'b0;
            write_r <= 1'b0;
            mc_r <= 1'b0;
            seen_r <= 1'b0;
            chan_r <= '0;
            status_r <= '1;
            left_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            wr_n_r <= wr_n_nxt;
            rd_n_r <= rd_n_nxt;
            oe_n_r <= oe_n_nxt;
            dat_r <= dat_nxt;
            dat_oe_r <= dat_oe_nxt;
            be_r <= be_nxt;
            be_oe_r <= be_oe_nxt;
            write_r <= write_nxt;
            mc_r <= mc_nxt;
            seen_r <= seen_nxt;
            chan_r <= chan_nxt;
            status_r <= status_nxt;
            left_r <= left_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign data_o = dat_r;
    assign data_oe_o = dat_oe_r;
    assign byte_lane_valid_o = be_r;
    assign byte_lane_valid_oe_o = {4{be_oe_r}};
    assign wr_req_low_o = wr_n_r;
    assign rd_req_low_o = rd_n_r;
    assign out_en_req_low_o = oe_n_r;
    assign busy_o = (st_r != S_IDLE);
    assign xfer_done_o = done_r;
    assign xfer_words_o = cnt_r;
    assign chan_status_o = status_r;

    // ==========================================================
    // Checks
    AST_RD_PUSH: assert property (@(posedge clock_i) disable iff (!rst_n)
        rx_push |-> !wr_n_r || !rd_n_r) else $error("read word taken without strobe");
    AST_RD_TA: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == S_CMD && rise && !write_r) |=> (dat_oe_r == '0) && !be_oe_r && !wr_n_r)
        else $error("read turnaround missing");
    AST_WR_TA: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == S_WR_TA || st_r == S_CMD) |-> (dat_oe_r[`UFS_ST_LSB +: 8] == 8'h00))
        else $error("status lane driven during write turnaround");
    AST_BE_HELD: assert property (@(posedge clock_i) disable iff (!rst_n)
        (mc_r && write_r && st_r inside {S_WR_TA, S_WR, S_END_TA}) |-> be_oe_r)
        else $error("lane-valid released during write");
    AST_WR_STOP: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == S_WR && rise && seen_r && rxf_q) |=> wr_n_r && (st_r == S_END_TA))
        else $error("write not ended on full slave");
    AST_END_TA: assert property (@(posedge clock_i) disable iff (!rst_n)
        ($rose(wr_n_r) && mc_r) |-> (st_r == S_END_TA) && xfer_done_o)
        else $error("request released without closing turnaround");
    AST_CMD_CODE: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == S_CMD) |-> (be_r == (write_r ? `UFS_CMD_WR : `UFS_CMD_RD))
        && (dat_r[`UFS_CHAN_LSB +: 8] == chan_r)) else $error("bad command phase");
    AST_IDLE_ONES: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st_r == S_IDLE && mc_r) [*2] |-> (dat_oe_r == `UFS_LANE_IDLE_OE) && be_oe_r
        && (be_r == `UFS_BE_ALL)) else $error("idle lanes not driven high");
    AST_245_OE: assert property (@(posedge clock_i) disable iff (!rst_n)
        !oe_n_r |-> (dat_oe_r == '0) && !be_oe_r) else $error("bus fight in 245 read");
    AST_245_RD: assert property (@(posedge clock_i) disable iff (!rst_n)
        $fell(rd_n_r) |-> !oe_n_r && !$past(oe_n_r)) else $error("read strobe before oe");
    AST_245_WR: assert property (@(posedge clock_i) disable iff (!rst_n)
        (!wr_n_r && !mc_r) |-> oe_n_r && (dat_oe_r == `UFS_LANE_ALL))
        else $error("245 write without driven bus");
endmodule : ufs_host
`default_nettype wire

// ==== tb/ufs_dev_model.sv ====
// Behavioural FIFO-bus slave: makes the bus clock and answers both bus modes.
// Assumes the bench resolves the shared data and lane wires from all enables.
`timescale 1ns/1ns
`default_nettype none
module ufs_dev_model #(
    // Words per full-size packet; the bench shrinks it so short runs split
    parameter int PKT = 256
) (
    input wire logic mc_i,
    input wire logic [3:0] nrd_i,
    input wire logic [3:0] nwr_i,
    input wire logic [31:0] d_i,
    input wire logic [3:0] lv_i,
    input wire logic wr_low_i,
    input wire logic rd_low_i,
    input wire logic oe_low_i,
    output logic clk_o,
    output logic [31:0] d_o,
    output logic [31:0] d_oe_o,
    output logic [3:0] lv_o,
    output logic lv_oe_o,
    output logic rx_data_avail_low_o,
    output logic tx_space_avail_low_o
);
    logic [1:0] ph = 2'h0;
    logic ack = 1'b1;
    logic [31:0] oe = 32'h0000FF00;
    logic [3:0] cmd, k = 4'h0, j = 4'h0, idx, lim;
    logic [7:0] chan;
    logic [35:0] mem [16];
    logic [3:0] npkt = 4'h0;
    logic short_pkt = 1'b0;
    // ==========================================================
    // Bus clock, free running; 62/63 ns halves give a 125 ns period
    initial clk_o = 1'b0;
    always
    begin
        #62 clk_o = 1'b1;
        #63 clk_o = 1'b0;
    end
    assign idx = mc_i ? k : j;
    assign lim = cmd[0] ? nwr_i : nrd_i;
    assign d_o = (mc_i && ph == 2'h0) ? 32'h0000EE00 : {28'h5A5A5A5, idx};
    assign lv_o = (idx == nrd_i - 4'h1) ? 4'h3 : 4'hF;
    assign d_oe_o = mc_i ? oe : {32{!oe_low_i}};
    // Lanes stay inputs through a write, so oe[0] is only set in a read
    assign lv_oe_o = mc_i ? oe[0] : !oe_low_i;
    assign rx_data_avail_low_o = mc_i ? ack : (j >= nrd_i);
    assign tx_space_avail_low_o = mc_i ? 1'b1 : (k >= nwr_i);
    // ==========================================================
    // Protocol engine, sampled on the rising bus clock
    always @(posedge clk_o)
    begin
        if (mc_i)
        begin
            case (ph)
            2'h0:
            begin
                k <= 4'h0;
                j <= 4'h0;
                if (!wr_low_i)
                begin
                    cmd <= lv_i;
                    chan <= d_i[7:0];
                    oe <= 32'h0;
                    ph <= 2'h1;
                end
            end
            2'h1:
            begin
                ack <= 1'b0;
                oe <= {32{!cmd[0]}};
                ph <= 2'h2;
            end
            2'h2:
            begin
                if (!wr_low_i)
                begin
                    if (cmd[0])
                        mem[k] <= {lv_i, d_i};
                    k <= k + 4'h1;
                end
                if (wr_low_i || k + 4'h1 == lim)
                begin
                    ack <= 1'b1;
                    oe <= 32'h0;
                    ph <= 2'h3;
                end
            end
            default:
                if (wr_low_i)
                begin
                    oe <= 32'h0000FF00;
                    ph <= 2'h0;
                    if (cmd[0])
                    begin
                        // Completed write: full packets first, then one short remainder
                        npkt <= 4'(k / PKT);
                        short_pkt <= (k % PKT) != 0;
                    end
                end
            endcase
        end
        else
        begin
            // One OUT store and one IN source only
            if (!wr_low_i && !tx_space_avail_low_o)
            begin
                mem[k] <= {lv_i, d_i};
                k <= k + 4'h1;
            end
            if (!rd_low_i && !oe_low_i && !rx_data_avail_low_o)
                j <= j + 4'h1;
        end
    end
endmodule : ufs_dev_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the FIFO-bus master against the slave model.
// Assumes tb/ufs_dev_model.sv and the core files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0, arst_n = 1'b0, mc = 1'b1, cv = 1'b0, cw = 1'b0;
    logic wv = 1'b0, rr = 1'b1, flt = 1'b0;
    logic [7:0] cc = 8'h00;
    logic [11:0] cl = 12'h000;
    logic [31:0] wd = 32'h0;
    logic [3:0] wb = 4'h0, nrd = 4'h0, nwr = 4'h0;
    logic cr, wrdy, rv, done, wrl, rdl, oel, bclk, slvoe, ack, txe, bsy;
    logic [31:0] rdd, mdo, moe, sd, soe, dw;
    logic [3:0] rdb, mlv, mlvoe, slv, lw;
    logic [11:0] nw;
    logic [7:0] cst;
    logic [35:0] q [$];
    int fails = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    // Undriven wires toggle so a stale value can never look valid
    always @(posedge clk) flt <= ~flt;
    assign dw = (moe & mdo) | (soe & sd) | (~(moe | soe) & {32{flt}});
    assign lw = (mlvoe & mlv) | ({4{slvoe}} & slv) | (~(mlvoe | {4{slvoe}}) & {4{flt}});
    ufs_host i_ufs_host (
        .clock_i(clk), .arst_n_i(arst_n), .mc_mode_i(mc), .cmd_valid_i(cv),
        .cmd_ready_o(cr), .cmd_write_i(cw), .cmd_chan_i(cc), .cmd_len_i(cl),
        .wr_data_i(wd), .wr_be_i(wb), .wr_valid_i(wv), .wr_ready_o(wrdy),
        .rd_data_o(rdd), .rd_be_o(rdb), .rd_valid_o(rv), .rd_ready_i(rr),
        .busy_o(bsy), .xfer_done_o(done), .xfer_words_o(nw), .chan_status_o(cst),
        .bus_clk_i(bclk), .data_i(dw), .data_o(mdo), .data_oe_o(moe),
        .byte_lane_valid_i(lw), .byte_lane_valid_o(mlv),
        .byte_lane_valid_oe_o(mlvoe), .wr_req_low_o(wrl), .rd_req_low_o(rdl),
        .out_en_req_low_o(oel), .rx_data_avail_low_i(ack), .tx_space_avail_low_i(txe)
    );
    ufs_dev_model #(.PKT(4)) i_ufs_dev_model (
        .mc_i(mc), .nrd_i(nrd), .nwr_i(nwr), .d_i(dw), .lv_i(lw), .wr_low_i(wrl),
        .rd_low_i(rdl), .oe_low_i(oel), .clk_o(bclk), .d_o(sd), .d_oe_o(soe),
        .lv_o(slv), .lv_oe_o(slvoe), .rx_data_avail_low_o(ack),
        .tx_space_avail_low_o(txe)
    );
    task automatic finish_test();
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [35:0] e, input logic [35:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic tick(inout int t);
        @(negedge clk);
        t++;
        if (t > 30000)
        begin
            fails++;
            finish_test();
        end
    endtask : tick
    task automatic put(input logic [31:0] d, input logic [3:0] b);
        int t;
        t = 0;
        @(posedge clk);
        wd <= d;
        wb <= b;
        wv <= 1'b1;
        do tick(t); while (wrdy !== 1'b1);
        @(posedge clk);
        wv <= 1'b0;
    endtask : put
    task automatic run(input logic w, input logic [7:0] c, input logic [11:0] n);
        int t;
        t = 0;
        @(posedge clk);
        cw <= w;
        cc <= c;
        cl <= n;
        cv <= 1'b1;
        do tick(t); while (cr !== 1'b1);
        @(posedge clk);
        cv <= 1'b0;
        @(negedge clk);
        chk(36'h1, {35'h0, bsy});
        do tick(t); while (done !== 1'b1);
        repeat (40) @(posedge clk);
        chk(36'h0, {35'h0, bsy});
    endtask : run
    // ==========================================================
    // Bus watch: the two ends never drive a wire together
    always @(posedge clk) if (rv === 1'b1 && rr) q.push_back({rdb, rdd});
    always @(negedge clk)
        if (arst_n)
            chk(36'h0, {mlvoe & {4{slvoe}}, moe & soe});
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (80) @(posedge clk);
        chk(36'h0FFFF00FF, {4'h0, moe});
        chk(36'hEE, {28'h0, cst});
        for (int i = 0; i < 16; i++)
            put({28'hC0FFEE0, 4'(i)}, (i == 15) ? 4'h3 : 4'hF);
        @(negedge clk);
        chk(36'h0, {35'h0, wrdy});
        nwr <= 4'h5;
        run(1'b1, 8'h01, 12'h010);
        chk(36'h5, {24'h0, nw});
        chk(36'h3, {31'h0, i_ufs_dev_model.npkt, i_ufs_dev_model.short_pkt});
        chk(36'h101, {24'h0, i_ufs_dev_model.cmd, i_ufs_dev_model.chan});
        for (int i = 0; i < 5; i++)
            chk({4'hF, 28'hC0FFEE0, 4'(i)}, i_ufs_dev_model.mem[i]);
        nwr <= 4'hF;
        run(1'b1, 8'h01, 12'h00B);
        chk(36'hB, {24'h0, nw});
        chk(36'h5, {31'h0, i_ufs_dev_model.npkt, i_ufs_dev_model.short_pkt});
        for (int i = 0; i < 11; i++)
            chk({(i == 10) ? 4'h3 : 4'hF, 28'hC0FFEE0, 4'(i + 5)},
                i_ufs_dev_model.mem[i]);
        nrd <= 4'h3;
        run(1'b0, 8'h02, 12'h008);
        chk(36'h3, {24'h0, nw});
        chk(36'h002, {24'h0, i_ufs_dev_model.cmd, i_ufs_dev_model.chan});
        rr <= 1'b0;
        nrd <= 4'hF;
        run(1'b0, 8'h01, 12'h004);
        chk(36'h4, {24'h0, nw});
        rr <= 1'b1;
        mc <= 1'b0;
        for (int i = 0; i < 3; i++)
            put({28'hD000000, 4'(i)}, (i == 2) ? 4'h1 : 4'hF);
        run(1'b1, 8'h00, 12'h003);
        chk(36'h3, {24'h0, nw});
        for (int i = 0; i < 3; i++)
            chk({(i == 2) ? 4'h1 : 4'hF, 28'hD000000, 4'(i)},
                i_ufs_dev_model.mem[i]);
        nrd <= 4'h2;
        run(1'b0, 8'h00, 12'h008);
        chk(36'h2, {24'h0, nw});
        chk(36'h9, 36'(q.size()));
        for (int i = 0; i < 9; i++)
            chk({(i == 2 || i == 8) ? 4'h3 : 4'hF, 28'h5A5A5A5,
                4'((i < 3) ? i : (i < 7) ? i - 3 : i - 7)}, q[i]);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
